/* File: hdl/acr_pkg.sv */
// constants and types for the converter control and result block
// Functional notes
// [R1] channel code selects single, differential, bandgap, ground
// [R2] enable bit powers converter; clearing aborts conversion
// [R3] start bit begins conversion; free running repeats
// [R4] first conversion after enable takes 25 cycles
// [R5] start bit reads one while busy; zero ignored
// [R6] auto trigger starts on selected source rising edge
// [R7] done flag sets when result bytes update
// [R8] interrupt request while flag and enable set
// [R9] vector acknowledge clears the done flag
// [R10] writing one clears done flag; zero keeps
// [R11] prescaler divides clock by 2 to 128
// [R12] result bytes at 0x78 and 0x79, read-only
// [R13] low byte read locks result until high read
// [R14] software reads low byte before high byte
// [R15] left justify puts bits 9..2 in high
// [R16] right justify default, bits 9..8 in high
// [R17] trigger source field selects eight trigger sources
// [R18] source switch to set flag makes edge; code does so only from a low source, never into free running
// [R19] channel and reference changes apply after conversion
// [R20] justify change reorders result bytes at once
// [R21] result while locked dropped, flag still set
// [R22] prescaler held reset while converter disabled
package acr_pkg;
    localparam logic [7:0] ACR_OFS_RES_LO = 8'h78;
    localparam logic [7:0] ACR_OFS_RES_HI = 8'h79;
    localparam logic [7:0] ACR_OFS_CTRL_A = 8'h7A;
    localparam logic [7:0] ACR_OFS_CTRL_B = 8'h7B;
    localparam logic [7:0] ACR_OFS_INSEL = 8'h7C;
    localparam int ACR_BIT_ON = 7;
    localparam int ACR_BIT_GO = 6;
    localparam int ACR_BIT_AUTO = 5;
    localparam int ACR_BIT_DONE = 4;
    localparam int ACR_BIT_IE = 3;
    localparam int ACR_BIT_LJ = 5;
    localparam logic [7:0] ACR_RESET_BYTE = 8'h00;
    localparam int ACR_FIRST_CYCLES = 25;
    localparam int ACR_NORMAL_CYCLES = 13;
    localparam logic [2:0] ACR_TRIG_FREE = 3'h0;
    localparam int ACR_RESULT_W = 10;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } acr_bus_t;

    typedef enum logic [1:0] {
        ACR_IDLE = 2'b00,
        ACR_CONV = 2'b01,
        ACR_DONE = 2'b11
    } acr_state_t;
endpackage

/* File: hdl/acr_prescaler.sv */
// converter clock enable divider
`timescale 1ns/1ps
`default_nettype none
module acr_prescaler
    import acr_pkg::*;
#(
    parameter int CNT_W = 7
)
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic run,
    input wire logic [2:0] div_sel,
    output logic tick
);
    // the slowest divide needs all seven counter bits in the mask
    if (CNT_W != 7)
    begin : g_bad_width
        $error("prescaler counter must be 7 bits");
    end

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] mask;

    // codes 0 and 1 both divide by two
    always_comb
    begin
        if (div_sel <= 3'h1)
            mask = CNT_W'(1);
        else
            mask = CNT_W'((1 << div_sel) - 1);
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            cnt_r <= '0;
        else if (!run)
            cnt_r <= '0; // [R22]
        else
            cnt_r <= cnt_r + CNT_W'(1);
    end

    assign tick = run && ((cnt_r & mask) == mask); // [R11]
endmodule
`default_nettype wire

/* File: hdl/acr_top.sv */
// converter control, trigger, prescaler and result registers
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module acr_top
    import acr_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic [7:0] TRIG_FLAGS,
    input wire logic [ACR_RESULT_W-1:0] CONV_RESULT,
    input wire logic IRQ_ACK,
    output logic IRQ_REQ,
    output logic CONV_POWER,
    output logic SAMPLE,
    output logic [4:0] CHANNEL_SELECT,
    output logic [1:0] REFERENCE_SELECT,
    output logic BUSY
);
    acr_bus_t bus;
    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    logic on_r, go_r, auto_r, done_r, ie_r;
    logic [2:0] div_r;
    logic [2:0] trig_sel_r;
    logic [7:0] insel_r;
    logic [ACR_RESULT_W-1:0] res_r;
    logic lock_r;
    logic first_r;
    logic trig_prev_r;
    logic [4:0] cyc_r;
    acr_state_t st_r;
    logic tick;
    logic wr_a, wr_b, wr_m, rd_lo, rd_hi;
    logic start_req, trig_lvl, trig_edge, finish;

    function automatic logic hit(input acr_bus_t b, input logic [7:0] a);
        return b.wr && b.addr == a;
    endfunction

    assign wr_a = hit(bus, ACR_OFS_CTRL_A);
    assign wr_b = hit(bus, ACR_OFS_CTRL_B);
    assign wr_m = hit(bus, ACR_OFS_INSEL);
    assign rd_lo = bus.rd && bus.addr == ACR_OFS_RES_LO;
    assign rd_hi = bus.rd && bus.addr == ACR_OFS_RES_HI;

    acr_prescaler #(.CNT_W(7)) u_div (
        .CLK(CLK),
        .RESETN(RESETN),
        .run(on_r),
        .div_sel(div_r),
        .tick(tick)
    );

    // free running uses the done flag as its own trigger level
    always_comb
    begin
        if (trig_sel_r == ACR_TRIG_FREE)
            trig_lvl = done_r;
        else
            trig_lvl = TRIG_FLAGS[trig_sel_r]; // [R17]
    end
    // prev tracks source after switch so edge comes from new level [R18]
    assign trig_edge = trig_lvl && !trig_prev_r && auto_r; // [R6]
    assign finish = st_r == ACR_CONV && tick
        && cyc_r == 5'(ACR_NORMAL_CYCLES - 1);

    always_comb
    begin
        start_req = 1'b0;
        if (wr_a && bus.wdata[ACR_BIT_GO])
            start_req = 1'b1; // [R3]
        if (trig_edge && on_r)
            start_req = 1'b1;
        if (st_r == ACR_DONE && auto_r && trig_sel_r == ACR_TRIG_FREE)
            start_req = 1'b1; // [R3]
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            trig_prev_r <= 1'b0;
        else if (wr_b && bus.wdata[2:0] == ACR_TRIG_FREE)
            trig_prev_r <= 1'b1; // [R18]
        else
            trig_prev_r <= trig_lvl;
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            on_r <= 1'b0;
            auto_r <= 1'b0;
            ie_r <= 1'b0;
            div_r <= 3'h0;
            trig_sel_r <= 3'h0;
            insel_r <= ACR_RESET_BYTE;
        end
        else
        begin
            if (wr_a)
            begin
                on_r <= bus.wdata[ACR_BIT_ON]; // [R2]
                auto_r <= bus.wdata[ACR_BIT_AUTO];
                ie_r <= bus.wdata[ACR_BIT_IE];
                div_r <= bus.wdata[2:0];
            end
            if (wr_b)
                trig_sel_r <= bus.wdata[2:0];
            if (wr_m)
                insel_r <= bus.wdata;
        end
    end

    // conversion sequencer; first run doubles the count minus one
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            st_r <= ACR_IDLE;
            go_r <= 1'b0;
            cyc_r <= 5'h0;
            first_r <= 1'b1;
        end
        else if (wr_a && !bus.wdata[ACR_BIT_ON])
        begin
            st_r <= ACR_IDLE; // [R2]
            go_r <= 1'b0;
            first_r <= 1'b1;
        end
        else
        begin
            case (st_r)
                ACR_IDLE, ACR_DONE:
                begin
                    st_r <= ACR_IDLE;
                    if (start_req && (on_r || (wr_a && bus.wdata[ACR_BIT_ON])))
                    begin
                        st_r <= ACR_CONV;
                        go_r <= 1'b1; // [R5]
                        cyc_r <= first_r
                            ? 5'(ACR_NORMAL_CYCLES - ACR_FIRST_CYCLES)
                            : 5'h0; // [R4]
                        first_r <= 1'b0;
                    end
                end
                ACR_CONV:
                begin
                    if (tick)
                        cyc_r <= cyc_r + 5'h1;
                    if (finish)
                    begin
                        st_r <= ACR_DONE;
                        go_r <= 1'b0; // [R5]
                    end
                end
                default:
                    st_r <= ACR_IDLE;
            endcase
        end
    end

    // set wins over both clears
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            done_r <= 1'b0;
        else if (finish)
            done_r <= 1'b1; // [R7] [R21]
        else if (IRQ_ACK)
            done_r <= 1'b0; // [R9]
        else if (wr_a && bus.wdata[ACR_BIT_DONE])
            done_r <= 1'b0; // [R10]
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            res_r <= '0;
            lock_r <= 1'b0;
        end
        else
        begin
            if (finish && !lock_r)
                res_r <= CONV_RESULT; // [R12] [R21]
            if (rd_lo)
                lock_r <= 1'b1; // [R13]
            else if (rd_hi)
                lock_r <= 1'b0; // [R13]
        end
    end

    // channel and reference latched only when not converting
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            CHANNEL_SELECT <= 5'h0;
            REFERENCE_SELECT <= 2'h0;
        end
        else if (st_r != ACR_CONV)
        begin
            CHANNEL_SELECT <= insel_r[4:0]; // [R1] [R19]
            REFERENCE_SELECT <= insel_r[7:6];
        end
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            IRQ_REQ <= 1'b0;
            CONV_POWER <= 1'b0;
            SAMPLE <= 1'b0;
            BUSY <= 1'b0;
        end
        else
        begin
            IRQ_REQ <= done_r && ie_r; // [R8]
            CONV_POWER <= on_r; // [R2]
            SAMPLE <= finish;
            BUSY <= go_r;
        end
    end

    // justification applied on read, so a change shows at once
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            RDATA <= ACR_RESET_BYTE;
        else if (!bus.rd)
            RDATA <= ACR_RESET_BYTE;
        else
        begin
            case (bus.addr)
                ACR_OFS_RES_LO:
                    RDATA <= insel_r[ACR_BIT_LJ]
                        ? {res_r[1:0], 6'h00} // [R15]
                        : res_r[7:0]; // [R16] [R20]
                ACR_OFS_RES_HI:
                    RDATA <= insel_r[ACR_BIT_LJ]
                        ? res_r[9:2] // [R15]
                        : {6'h00, res_r[9:8]}; // [R16]
                ACR_OFS_CTRL_A:
                    RDATA <= {on_r, go_r, auto_r, done_r, ie_r, div_r};
                ACR_OFS_CTRL_B:
                    RDATA <= {5'h00, trig_sel_r};
                ACR_OFS_INSEL:
                    RDATA <= insel_r;
                default:
                    RDATA <= ACR_RESET_BYTE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: testbench/acr_analog_model.sv */
// behavioural analog front end feeding the conversion result
`timescale 1ns/1ps
`default_nettype none
module acr_analog_model
    import acr_pkg::*;
(
    input wire logic CLK,
    input wire logic powered,
    input wire logic [4:0] chan,
    output logic [ACR_RESULT_W-1:0] level
);
    logic [ACR_RESULT_W-1:0] junk_r = '0;
    always_ff @(posedge CLK)
    begin
        junk_r <= ~junk_r;
    end
    // unpowered front end toggles so a stale sample looks right only on channel 9, on every other cycle
    assign level = powered ? ({chan, 5'h1A} ^ 10'h2C5) : junk_r;
endmodule
`default_nettype wire

/* File: testbench/acr_top_checker.sv */
// port-level assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acr_top_checker
    import acr_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic IRQ_ACK,
    input wire logic IRQ_REQ,
    input wire logic CONV_POWER,
    input wire logic SAMPLE,
    input wire logic [4:0] CHANNEL_SELECT,
    input wire logic [1:0] REFERENCE_SELECT,
    input wire logic BUSY
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    a_power_off_write: assert property (WR && ADDR == ACR_OFS_CTRL_A
        && !WDATA[ACR_BIT_ON] |-> ##[1:2] !CONV_POWER)
        else $error("converter stayed powered after disable");
    a_unpowered_idle: assert property (!CONV_POWER [*3]
        |-> !BUSY && !SAMPLE) else $error("activity while unpowered");
    a_busy_on_go: assert property (WR && ADDR == ACR_OFS_CTRL_A
        && WDATA[ACR_BIT_ON] && WDATA[ACR_BIT_GO] |-> ##[1:3] BUSY)
        else $error("start write did not raise busy");
    a_sample_pulse: assert property (SAMPLE |=> !SAMPLE)
        else $error("sample pulse longer than one cycle");
    a_sample_after_busy: assert property (SAMPLE |-> $past(BUSY, 2))
        else $error("completion without a conversion");
    a_irq_has_cause: assert property ($rose(IRQ_REQ) |-> $past(SAMPLE)
        || $past(SAMPLE, 2) || $past(WR, 2))
        else $error("interrupt request without cause");
    a_ack_clears_irq: assert property (IRQ_ACK ##1 !SAMPLE
        |=> !IRQ_REQ) else $error("acknowledge left request up");
    a_select_frozen: assert property (BUSY [*4] |->
        $stable(CHANNEL_SELECT) && $stable(REFERENCE_SELECT))
        else $error("input select moved during conversion");
    a_rdata_quiet: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside read answer cycle");
endmodule
bind acr_top acr_top_checker i_chk (.CLK, .RESETN, .ADDR, .WDATA, .WR,
    .RD, .RDATA, .IRQ_ACK, .IRQ_REQ, .CONV_POWER, .SAMPLE,
    .CHANNEL_SELECT, .REFERENCE_SELECT, .BUSY);
`default_nettype wire

/* File: testbench/acr_top_bench.sv */
// self-checking bench for the converter control and result block
`timescale 1ns/1ps
`default_nettype none
module acr_top_bench;
    import acr_pkg::*;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic IRQ_ACK = 1'b0;
    logic [7:0] TRIG_FLAGS = 8'h00;
    logic [7:0] RDATA;
    logic [ACR_RESULT_W-1:0] CONV_RESULT;
    logic IRQ_REQ, CONV_POWER, SAMPLE, BUSY;
    logic [4:0] CHANNEL_SELECT;
    logic [1:0] REFERENCE_SELECT;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int n[8];
    int f;
    logic [7:0] lo, hi, st;
    acr_top i_dut (.*);
    acr_analog_model i_front (.CLK, .powered(CONV_POWER),
        .chan(CHANNEL_SELECT), .level(CONV_RESULT));
    always #50 CLK = ~CLK;
    // a hang is cut short well past the longest expected run
    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            num_errors++;
            conclude();
        end
    end
    function automatic logic [9:0] lvl(input logic [4:0] c);
        return {c, 5'h1A} ^ 10'h2C5;
    endfunction
    task automatic conclude;
        if (num_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        @(posedge CLK);
        d = RDATA;
    endtask
    task automatic rpair;
        rd(ACR_OFS_RES_LO, lo);
        rd(ACR_OFS_RES_HI, hi);
    endtask
    task automatic settle(input logic lvl_want);
        for (int k = 0; k < 4000 && BUSY !== lvl_want; k++)
            @(posedge CLK);
    endtask
    // cold start powers down first so the divider phase is known
    task automatic conv(input logic [7:0] ctl, input logic cold,
                        output int m);
        if (cold)
            wr(ACR_OFS_CTRL_A, 8'h00);
        wr(ACR_OFS_CTRL_A, ctl);
        settle(1'b1);
        for (m = 0; m < 4000 && BUSY === 1'b1; m++)
            @(posedge CLK);
    endtask
    task automatic s_regs;
        wr(ACR_OFS_RES_LO, 8'hFF);
        for (int a = 8'h77; a < 8'h7D; a++)
        begin
            rd(8'(a), st);
            chk(16'(st), 16'h0000);
        end
    endtask
    task automatic s_timing;
        wr(ACR_OFS_INSEL, 8'h03);
        for (int c = 0; c < 8; c++)
            conv(8'hD0 | 8'(c), 1'b1, n[c]);
        for (int c = 0; c < 8; c++)
            chk(16'(n[c] - n[1]),
                16'(ACR_FIRST_CYCLES * ((c < 2 ? 2 : 1 << c) - 2)));
        conv(8'hD1, 1'b0, f);
        chk(16'((n[1] - f) inside {[23:25]}), 16'h0001);
    endtask
    task automatic s_result;
        rd(ACR_OFS_CTRL_A, st);
        chk(16'(st & 8'h50), 16'h0010);
        rpair();
        chk({hi, lo}, {6'h00, lvl(5'h03)});
        wr(ACR_OFS_INSEL, 8'h23);
        rpair();
        chk({hi, lo}, {lvl(5'h03), 6'h00});
    endtask
    task automatic s_lock;
        rd(ACR_OFS_RES_LO, lo);
        wr(ACR_OFS_INSEL, 8'h25);
        conv(8'hD0, 1'b0, f);
        rd(ACR_OFS_CTRL_A, st);
        chk(16'({st[4], CHANNEL_SELECT}), 16'h0025);
        rd(ACR_OFS_RES_HI, hi);
        chk(16'(hi), 16'(lvl(5'h03) >> 2));
        rpair();
        chk({hi, lo}, {lvl(5'h03), 6'h00});
    endtask
    task automatic s_busy;
        wr(ACR_OFS_CTRL_A, 8'hD7);
        settle(1'b1);
        wr(ACR_OFS_INSEL, 8'h21);
        chk(16'(CHANNEL_SELECT), 16'h0005);
        wr(ACR_OFS_CTRL_A, 8'h87);
        chk(16'(BUSY), 16'h0001);
        wr(ACR_OFS_CTRL_A, 8'h07);
        repeat (3) @(posedge CLK);
        rd(ACR_OFS_CTRL_A, st);
        chk(16'({CONV_POWER, BUSY, st}), 16'h0007);
        wr(ACR_OFS_INSEL, 8'hDE);
        @(posedge CLK);
        chk(16'({REFERENCE_SELECT, CHANNEL_SELECT}), 16'h007E);
    endtask
    task automatic s_irq;
        conv(8'hC0, 1'b1, f);
        wr(ACR_OFS_CTRL_A, 8'h88);
        rd(ACR_OFS_CTRL_A, st);
        chk(16'({st[4], IRQ_REQ}), 16'h0003);
        IRQ_ACK <= 1'b1;
        @(posedge CLK);
        IRQ_ACK <= 1'b0;
        repeat (2) @(posedge CLK);
        chk(16'(IRQ_REQ), 16'h0000);
        conv(8'hC8, 1'b0, f);
        wr(ACR_OFS_CTRL_A, 8'h98);
        rd(ACR_OFS_CTRL_A, st);
        chk(16'({st[4], IRQ_REQ}), 16'h0000);
    endtask
    task automatic s_trig;
        wr(ACR_OFS_CTRL_B, 8'h01);
        wr(ACR_OFS_CTRL_A, 8'hA0);
        for (int c = 1; c < 8; c++)
        begin
            TRIG_FLAGS <= 8'h01 << c;
            @(posedge CLK);
            wr(ACR_OFS_CTRL_B, 8'(c));
            settle(1'b1);
            chk(16'(BUSY), 16'h0001);
            settle(1'b0);
            TRIG_FLAGS <= 8'h00;
            @(posedge CLK);
            TRIG_FLAGS <= 8'h01 << c;
            settle(1'b1);
            chk(16'(BUSY), 16'h0001);
            settle(1'b0);
        end
        wr(ACR_OFS_CTRL_B, 8'h00);
        repeat (4) @(posedge CLK);
        chk(16'(BUSY), 16'h0000);
        wr(ACR_OFS_CTRL_A, 8'hE0);
        settle(1'b1);
        settle(1'b0);
        settle(1'b1);
        chk(16'(BUSY), 16'h0001);
    endtask
    initial
    begin
        repeat (3) @(posedge CLK);
        RESETN <= 1'b1;
        @(posedge CLK);
        s_regs();
        s_timing();
        s_result();
        s_lock();
        s_busy();
        s_irq();
        s_trig();
        conclude();
    end
endmodule
`default_nettype wire
